//--- inc/bts_pkg.sv
`default_nettype none
package bts_pkg;

  // ----------------------------------------
  // Instruction bytes and opcode fields
  // ----------------------------------------
  localparam logic [7:0] PFX_BIT = 8'hcb;
  localparam logic [7:0] PFX_IDX_X = 8'hdd;
  localparam logic [7:0] PFX_IDX_Y = 8'hfd;
  localparam logic [1:0] GRP_TEST = 2'b01;
  localparam logic [1:0] GRP_SET = 2'b11;
  localparam logic [2:0] CODE_MEM = 3'b110;
  localparam logic [2:0] CODE_HIGH = 3'b100;
  localparam logic [2:0] CODE_LOW = 3'b101;

  // ----------------------------------------
  // Flag byte layout and reset values
  // ----------------------------------------
  localparam int F_SIGN = 7;
  localparam int F_ZERO = 6;
  localparam int F_HALF = 4;
  localparam int F_PAR = 2;
  localparam int F_SUB = 1;
  localparam int F_CARRY = 0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  // ----------------------------------------
  // Timing: one clock stands for one T-state
  // ----------------------------------------
  localparam int TS_CLKS = 1;
  localparam logic [2:0] LEN1 = 3'(1 * TS_CLKS);
  localparam logic [2:0] LEN3 = 3'(3 * TS_CLKS);
  localparam logic [2:0] LEN4 = 3'(4 * TS_CLKS);
  localparam logic [2:0] LEN5 = 3'(5 * TS_CLKS);
  localparam logic [4:0] TOT_REG = 5'(8 * TS_CLKS);
  localparam logic [4:0] TOT_IDX_TEST = 5'(20 * TS_CLKS);
  localparam logic [4:0] TOT_IDX_SET = 5'(23 * TS_CLKS);

  // ----------------------------------------
  // Machine cycle sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b100,
    S_FETCH = 3'b000,
    S_PFX = 3'b001,
    S_DISP = 3'b011,
    S_OP = 3'b010,
    S_RD = 3'b110,
    S_WR = 3'b111
  } bts_state_e;

endpackage
`default_nettype wire

//--- logic/bts_bitop.sv
`timescale 1ns/1ps
`default_nettype none
module bts_bitop (
  // Operand and opcode
  input wire logic [7:0] i_data,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_flags,
  // Results
  output logic [7:0] o_result,
  output logic [7:0] o_test_flags
);

  // ----------------------------------------
  // Bit select, set and flag image
  // ----------------------------------------
  wire logic [7:0] mask = 8'h01 << i_bit;
  wire logic picked = i_data[i_bit];

  // Sign and parity are left as they were, one legal form of undefined.
  always_comb begin
    o_result = i_data | mask;
    o_test_flags = i_flags;
    o_test_flags[bts_pkg::F_ZERO] = ~picked;
    o_test_flags[bts_pkg::F_HALF] = 1'b1;
    o_test_flags[bts_pkg::F_SUB] = 1'b0;
  end

endmodule
`default_nettype wire

//--- logic/bts_ea.sv
`timescale 1ns/1ps
`default_nettype none
module bts_ea (
  // Base and displacement
  input wire logic [15:0] i_base,
  input wire logic [7:0] i_disp,
  input wire logic i_use_disp,
  // Effective address
  output logic [15:0] o_ea
);

  // ----------------------------------------
  // Signed offset, wraps modulo 64K
  // ----------------------------------------
  wire logic [15:0] sext = {{8{i_disp[7]}}, i_disp};
  wire logic [15:0] offs = i_use_disp ? sext : 16'h0000;

  assign o_ea = 16'(i_base + offs);

endmodule
`default_nettype wire

//--- logic/bts_unit.sv
// Operation
// - CB then 01 b r tests register bit
// - Codes 0-5 registers, 7 accumulator, 6 memory
// - Bit field 000 is bit 0, 111 bit 7
// - Test: Z=not bit, H set, N clear, C kept
// - CB 01 b 110 tests byte at pointer_pair
// - DD CB d 01 b 110 tests index_x+d
// - FD CB d 01 b 110 tests index_y+d
// - Indexed test takes 4,4,3,5,4 states
// - CB 11 b r sets register bit, flags kept
// - Pointer_pair set reads then writes byte back
// - Index_x set reads, rewrites, flags untouched
// - FD CB d 11 b 110 sets index_y+d
// - Indexed set takes 4,4,3,5,4,3 states
`timescale 1ns/1ps
`default_nettype none
module bts_unit (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Memory bus
  output logic [15:0] o_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_mem_rdata,
  // Index registers of the core
  input wire logic [15:0] i_index_x,
  input wire logic [15:0] i_index_y,
  // Status
  output logic [7:0] o_flags,
  output logic [15:0] o_pc,
  output logic o_done,
  output logic o_illegal,
  // Register view
  input wire logic [2:0] i_view_sel,
  output logic [7:0] o_view_data
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  bts_pkg::bts_state_e state;
  bts_pkg::bts_state_e next_state;
  logic [2:0] tcnt;
  logic [7:0] regs [8];
  logic ix, sel_y;
  logic [7:0] disp, op_q;
  logic [15:0] ea_q;
  logic rd_q;
  logic [7:0] rdata_q;
  logic fin, ill, reg_we, flag_we;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [2:0] st_len =
    (state == bts_pkg::S_DISP || state == bts_pkg::S_WR) ?
      bts_pkg::LEN3 :
    (state == bts_pkg::S_OP && ix) ? bts_pkg::LEN5 :
    (state == bts_pkg::S_IDLE) ? bts_pkg::LEN1 :
    bts_pkg::LEN4;
  wire logic last = (tcnt == 3'(st_len - 3'd1));
  wire logic is_cb = (rdata_q == bts_pkg::PFX_BIT);
  wire logic is_dd = (rdata_q == bts_pkg::PFX_IDX_X);
  wire logic is_fd = (rdata_q == bts_pkg::PFX_IDX_Y);
  wire logic [7:0] bsel = (state == bts_pkg::S_OP) ? rdata_q : op_q;
  wire logic [2:0] rf = bsel[2:0];
  wire logic is_test = (bsel[7:6] == bts_pkg::GRP_TEST);
  wire logic is_set = (bsel[7:6] == bts_pkg::GRP_SET);
  wire logic is_mem = (rf == bts_pkg::CODE_MEM);
  // Indexed prefixes only reach memory; a register code there is refused.
  wire logic op_ok = (is_test || is_set) && (!ix || is_mem);
  wire logic [15:0] ptr =
    {regs[bts_pkg::CODE_HIGH], regs[bts_pkg::CODE_LOW]};
  wire logic [15:0] base =
    !ix ? ptr : (sel_y ? i_index_y : i_index_x);
  wire logic [7:0] opnd =
    (state == bts_pkg::S_RD) ? rdata_q : regs[rf];
  wire logic [7:0] bit_res, test_flags;
  wire logic [15:0] ea;
  wire logic code_next = (next_state == bts_pkg::S_FETCH) ||
    (next_state == bts_pkg::S_PFX) || (next_state == bts_pkg::S_DISP) ||
    (next_state == bts_pkg::S_OP);
  wire logic [15:0] next_addr = code_next ? o_pc :
    ((state == bts_pkg::S_OP) ? ea : ea_q);

  bts_bitop bts_bitop_i (
    .i_data(opnd),
    .i_bit(bsel[5:3]),
    .i_flags(o_flags),
    .o_result(bit_res),
    .o_test_flags(test_flags)
  );

  bts_ea bts_ea_i (
    .i_base(base),
    .i_disp(disp),
    .i_use_disp(ix),
    .o_ea(ea)
  );

  // ----------------------------------------
  // Machine cycle sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    fin = 1'b0;
    ill = 1'b0;
    reg_we = 1'b0;
    flag_we = 1'b0;
    if (last) begin
      case (state)
        bts_pkg::S_IDLE: next_state = bts_pkg::S_FETCH;
        bts_pkg::S_FETCH: begin
          if (is_cb) begin
            next_state = bts_pkg::S_OP;
          end else if (is_dd || is_fd) begin
            next_state = bts_pkg::S_PFX;
          end else begin
            fin = 1'b1;
            ill = 1'b1;
          end
        end
        bts_pkg::S_PFX: begin
          if (is_cb) begin
            next_state = bts_pkg::S_DISP;
          end else begin
            fin = 1'b1;
            ill = 1'b1;
          end
        end
        bts_pkg::S_DISP: next_state = bts_pkg::S_OP;
        bts_pkg::S_OP: begin
          if (!op_ok) begin
            fin = 1'b1;
            ill = 1'b1;
          end else if (!is_mem) begin
            fin = 1'b1;
            reg_we = is_set;
            flag_we = is_test;
          end else begin
            next_state = bts_pkg::S_RD;
          end
        end
        bts_pkg::S_RD: begin
          if (is_test) begin
            fin = 1'b1;
            flag_we = 1'b1;
          end else begin
            next_state = bts_pkg::S_WR;
          end
        end
        bts_pkg::S_WR: fin = 1'b1;
        default: next_state = bts_pkg::S_IDLE;
      endcase
      if (fin) begin
        next_state = bts_pkg::S_FETCH;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= bts_pkg::S_IDLE;
      tcnt <= 3'd0;
    end else begin
      state <= next_state;
      tcnt <= last ? 3'd0 : 3'(tcnt + 3'd1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ix <= 1'b0;
      sel_y <= 1'b0;
      disp <= 8'h00;
      op_q <= 8'h00;
      ea_q <= 16'h0000;
    end else if (last) begin
      if (state == bts_pkg::S_FETCH) begin
        ix <= is_dd || is_fd;
        sel_y <= is_fd;
      end
      if (state == bts_pkg::S_DISP)
        disp <= rdata_q;
      if (state == bts_pkg::S_OP) begin
        op_q <= rdata_q;
        ea_q <= ea;
      end
    end
  end

  // Read data is sampled one clock after the strobe, so every read
  // cycle needs at least three states before it is decided.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      rd_q <= o_mem_rd;
      if (rd_q)
        rdata_q <= i_mem_rdata;
    end
  end

  // ----------------------------------------
  // Bus strobes and program counter
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr <= bts_pkg::PC_RST;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_wdata <= 8'h00;
      o_pc <= bts_pkg::PC_RST;
    end else begin
      o_mem_rd <= last && (next_state != bts_pkg::S_WR);
      o_mem_wr <= last && (next_state == bts_pkg::S_WR);
      if (last) begin
        o_addr <= next_addr;
      end
      if (last && code_next) begin
        o_pc <= 16'(o_pc + 16'd1);
      end
      if (last && state == bts_pkg::S_RD) begin
        o_wdata <= bit_res;
      end
    end
  end

  // ----------------------------------------
  // Flags, status and register file
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flags <= bts_pkg::FLAGS_RST;
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_view_data <= bts_pkg::REG_RST;
    end else begin
      if (flag_we)
        o_flags <= test_flags;
      o_done <= fin;
      o_illegal <= ill;
      o_view_data <= (i_view_sel == bts_pkg::CODE_MEM) ?
        o_flags : regs[i_view_sel];
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_reg
    always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
        regs[g] <= bts_pkg::REG_RST;
      end else if (reg_we && rf == 3'(g)) begin
        regs[g] <= bit_res;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [4:0] cyc;
  logic [7:0] op_sh, rd_sh;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc <= 5'd1;
      op_sh <= 8'h00;
      rd_sh <= 8'h00;
    end else begin
      cyc <= (fin || state == bts_pkg::S_IDLE) ? 5'd1 : 5'(cyc + 5'd1);
      op_sh <= opnd;
      if (state == bts_pkg::S_RD) begin
        rd_sh <= rdata_q;
      end
    end
  end

  property p_reg_len;
    @(posedge i_mclk) disable iff (!i_nrst)
    fin && !ill && state == bts_pkg::S_OP |-> cyc == bts_pkg::TOT_REG;
  endproperty
  a_reg_len: assert property (p_reg_len)
    else $error("register form length wrong");
  property p_idx_test_len;
    @(posedge i_mclk) disable iff (!i_nrst)
    fin && ix && state == bts_pkg::S_RD |-> cyc == bts_pkg::TOT_IDX_TEST;
  endproperty
  a_idx_test_len: assert property (p_idx_test_len)
    else $error("indexed test length wrong");
  property p_idx_set_len;
    @(posedge i_mclk) disable iff (!i_nrst)
    fin && ix && state == bts_pkg::S_WR |-> cyc == bts_pkg::TOT_IDX_SET;
  endproperty
  a_idx_set_len: assert property (p_idx_set_len)
    else $error("indexed set length wrong");
  property p_test_flags;
    @(posedge i_mclk) disable iff (!i_nrst)
    flag_we |=> o_flags[bts_pkg::F_HALF] && !o_flags[bts_pkg::F_SUB] &&
      o_flags[bts_pkg::F_CARRY] == $past(o_flags[bts_pkg::F_CARRY]) &&
      o_flags[bts_pkg::F_ZERO] == !op_sh[op_q[5:3]];
  endproperty
  a_test_flags: assert property (p_test_flags)
    else $error("bit test flags wrong");
  property p_set_flags;
    @(posedge i_mclk) disable iff (!i_nrst)
    fin && is_set |=> $stable(o_flags);
  endproperty
  a_set_flags: assert property (p_set_flags)
    else $error("bit set changed flags");
  property p_set_write;
    @(posedge i_mclk) disable iff (!i_nrst)
    o_mem_wr |-> o_wdata == (rd_sh | (8'h01 << op_q[5:3])) &&
      o_addr == ea_q;
  endproperty
  a_set_write: assert property (p_set_write)
    else $error("write back data wrong");
  property p_idx_addr;
    @(posedge i_mclk) disable iff (!i_nrst)
    o_mem_rd && state == bts_pkg::S_RD && ix |-> o_addr ==
      16'((sel_y ? i_index_y : i_index_x) + {{8{disp[7]}}, disp});
  endproperty
  a_idx_addr: assert property (p_idx_addr)
    else $error("indexed address wrong");
  property p_wr_after_rd;
    @(posedge i_mclk) disable iff (!i_nrst)
    o_mem_wr |-> !o_mem_rd ##1 !o_mem_wr [*2] ##1 o_mem_rd;
  endproperty
  a_wr_after_rd: assert property (p_wr_after_rd)
    else $error("write cycle length wrong");

endmodule
`default_nettype wire

//--- verif/bts_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bts_mem_model (
  // Clock
  input wire logic i_mclk,
  // Memory bus from the unit
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  // ----------------------------------------
  // Zero wait state storage
  // ----------------------------------------
  logic [7:0] mem [65536];
  logic [15:0] last_addr = 16'h0000;
  logic [7:0] last_data = 8'h00;
  int wr_count = 0;

  initial o_rdata = 8'h5a;

  // Outside its answer slot the data bus toggles, so a stale byte can never
  // pass for a fresh one.
  always @(posedge i_mclk) begin
    if (i_rd) begin
      o_rdata <= mem[i_addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
      last_addr <= i_addr;
      last_data <= i_wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/bts_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bts_unit_bench;
  // ----------------------------------------
  // Clock, wiring and counters
  // ----------------------------------------
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [15:0] i_index_x = 16'h2000;
  logic [15:0] i_index_y = 16'hfff8;
  logic [2:0] i_view_sel = 3'h0;
  logic [15:0] o_addr, o_pc;
  logic o_mem_rd, o_mem_wr, o_done, o_illegal;
  logic [7:0] o_wdata, i_mem_rdata, o_flags, o_view_data;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int last_done = 0;
  logic [7:0] prog [44] = '{8'hcb, 8'hff, 8'hcb, 8'h7f, 8'hcb, 8'h47,
    8'hcb, 8'hc0, 8'hcb, 8'hc9, 8'hcb, 8'hd2, 8'hcb, 8'hdb, 8'hcb, 8'he4,
    8'hcb, 8'hed, 8'hcb, 8'h66, 8'hcb, 8'hce, 8'hdd, 8'hcb, 8'hfc, 8'h5e,
    8'hfd, 8'hcb, 8'h7f, 8'hc6, 8'hfd, 8'hcb, 8'h08, 8'h4e, 8'hdd, 8'hcb,
    8'h05, 8'hd6, 8'hcb, 8'h87, 8'hdd, 8'hcb, 8'h00, 8'hc7};

  always #2.5 i_mclk = ~i_mclk;

  bts_unit bts_unit_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_addr(o_addr),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_wdata(o_wdata),
    .i_mem_rdata(i_mem_rdata), .i_index_x(i_index_x),
    .i_index_y(i_index_y), .o_flags(o_flags), .o_pc(o_pc),
    .o_done(o_done), .o_illegal(o_illegal), .i_view_sel(i_view_sel),
    .o_view_data(o_view_data));

  bts_mem_model bts_mem_model_i (.i_mclk(i_mclk), .i_addr(o_addr),
    .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_wdata(o_wdata),
    .o_rdata(i_mem_rdata));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The whole program runs in well under a thousand clocks.
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end

  // A length of zero skips the spacing check between completions.
  task automatic step(input int len, input logic ill, input logic [7:0] fl,
                      input int wrs);
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (o_done !== 1'b1 && n < 64);
    check("done", {15'h0000, o_done}, 16'h0001);
    if (len > 0) begin
      check("length", 16'(cycles - last_done), 16'(len));
    end
    last_done = cycles;
    check("illegal", {15'h0000, o_illegal}, {15'h0000, ill});
    if (!ill) begin
      check("flags", {8'h00, o_flags & 8'h53}, {8'h00, fl});
    end
    check("writes", 16'(bts_mem_model_i.wr_count), 16'(wrs));
  endtask

  task automatic view(input logic [2:0] sel, input logic [7:0] exp);
    @(posedge i_mclk);
    i_view_sel <= sel;
    @(posedge i_mclk);
    @(posedge i_mclk);
    #1;
    check("register view", {8'h00, o_view_data}, {8'h00, exp});
  endtask

  task automatic last_write(input logic [15:0] a, input logic [7:0] d);
    check("write address", bts_mem_model_i.last_addr, a);
    check("write data", {8'h00, bts_mem_model_i.last_data}, {8'h00, d});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (12) @(posedge i_mclk);
    #1;
    check("pc in reset", o_pc, 16'h0000);
    check("read in reset", {15'h0000, o_mem_rd}, 16'h0000);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    #1;
    check("first read", {15'h0000, o_mem_rd}, 16'h0001);
    check("first address", o_addr, 16'h0000);
    check("pc after first fetch", o_pc, 16'h0001);
    $display("test reset finished");
  endtask

  task automatic t_accumulator();
    step(0, 1'b0, 8'h00, 0);
    view(3'b111, 8'h80);
    step(8, 1'b0, 8'h10, 0);
    step(8, 1'b0, 8'h50, 0);
    $display("test accumulator finished");
  endtask

  // Each register gets its own bit, so a crossed code or bit shows at once.
  task automatic t_registers();
    for (int r = 0; r < 6; r++) begin
      step(8, 1'b0, 8'h50, 0);
      view(3'(r), 8'(1 << r));
    end
    $display("test registers finished");
  endtask

  task automatic t_pointer();
    step(12, 1'b0, 8'h10, 0);
    step(15, 1'b0, 8'h10, 1);
    last_write(16'h1020, 8'h12);
    $display("test pointer pair finished");
  endtask

  task automatic t_indexed();
    step(20, 1'b0, 8'h50, 1);
    step(23, 1'b0, 8'h50, 2);
    last_write(16'h0077, 8'h81);
    step(20, 1'b0, 8'h10, 2);
    step(23, 1'b0, 8'h10, 3);
    last_write(16'h2005, 8'h04);
    $display("test indexed finished");
  endtask

  task automatic t_refused();
    step(8, 1'b1, 8'h00, 3);
    step(16, 1'b1, 8'h00, 3);
    step(4, 1'b1, 8'h00, 3);
    $display("test refused finished");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int a = 0; a < 65536; a++) begin
      bts_mem_model_i.mem[a] = 8'h00;
    end
    for (int a = 0; a < 44; a++) begin
      bts_mem_model_i.mem[a] = prog[a];
    end
    bts_mem_model_i.mem[16'h1020] = 8'h10;
    bts_mem_model_i.mem[16'h1ffc] = 8'hf7;
    bts_mem_model_i.mem[16'h0077] = 8'h80;
    t_reset();
    t_accumulator();
    t_registers();
    t_pointer();
    t_indexed();
    t_refused();
    summarize();
  end
endmodule
`default_nettype wire
